/* sirqh_periph.sv */
/* Serial IRQ peripheral model that pulls slots 3 and 17 low on request.
   Assumes a pulled-up line and sight of the host output enable. */
`timescale 1ns/1ps
module sirqh_periph
(
    // Link clock and host enable
    input wire logic i_lpc_clk,
    input wire logic i_host_oe,
    // Slots to assert
    input wire logic i_slot3_low,
    input wire logic i_slot17_low,
    // Pull-down of the shared line
    output logic o_drive_low
);
    int h = 0;
    int k = 100;
    initial o_drive_low = 1'b0;
    // Only a host drive of five clocks or more is a start; slot n is held low around its sample phase
    always @(posedge i_lpc_clk)
    begin
        h <= i_host_oe ? h + 1 : 0;
        k <= (!i_host_oe && h >= 5) ? 0 : k + 1;
        o_drive_low <= (i_slot3_low && k inside {[9:10]}) || (i_slot17_low && k inside {[51:52]});
    end
endmodule

/* sirqh_pkg.sv */
/*
 * Shared constants and types for the serial IRQ host and clock-stop idle timing block.
 * Assumes an index/data style configuration port driven by logic on the system clock.
 */
package sirqh_pkg;

    // Configuration indices
    localparam logic [7:0] SIRQH_IDX_IDLE_CNT = 8'h3D;
    localparam logic [7:0] SIRQH_IDX_MODE = 8'h40;
    localparam logic [7:0] SIRQH_IDX_EXC = 8'hF0;
    localparam logic [7:0] SIRQH_IDX_CLKG = 8'hF1;

    // Field positions
    localparam int SIRQH_IDLE_LSB = 2;
    localparam int SIRQH_IDLE_MSB = 7;
    localparam int SIRQH_MODE_EN_BIT = 7;
    localparam int SIRQH_MODE_MD_BIT = 6;
    localparam int SIRQH_MODE_FMT_LSB = 2;
    localparam int SIRQH_MODE_FMT_MSB = 5;
    localparam int SIRQH_MODE_PW_LSB = 0;
    localparam int SIRQH_MODE_PW_MSB = 1;
    localparam int SIRQH_EXC_IOCHK_LK_BIT = 5;
    localparam int SIRQH_EXC_SMI_LK_BIT = 4;
    localparam int SIRQH_EXC_IOCHK_EN_BIT = 1;
    localparam int SIRQH_EXC_SMI_EN_BIT = 0;
    localparam int SIRQH_CLKG_BIT = 0;

    // Reset values and constants
    localparam logic [5:0] SIRQH_IDLE_RST = 6'h00;
    localparam logic [3:0] SIRQH_FMT_21SLOT = 4'h4;
    localparam logic [1:0] SIRQH_PW_RST = 2'h0;
    localparam logic SIRQH_CLKG_RST = 1'b1;
    localparam logic [7:0] SIRQH_RD_UNMAPPED = 8'h00;

    // Start pulse width codes and widths in LPC clocks
    localparam logic [1:0] SIRQH_PW_CODE_4 = 2'h0;
    localparam logic [1:0] SIRQH_PW_CODE_6 = 2'h1;
    localparam logic [1:0] SIRQH_PW_CODE_8 = 2'h2;
    localparam logic [3:0] SIRQH_PW_CLK_4 = 4'h4;
    localparam logic [3:0] SIRQH_PW_CLK_6 = 4'h6;
    localparam logic [3:0] SIRQH_PW_CLK_8 = 4'h8;

    // Frame layout in LPC clocks
    localparam logic [4:0] SIRQH_NUM_SLOTS = 5'h15;
    localparam logic [1:0] SIRQH_SLOT_PHASES = 2'h3;
    localparam logic [4:0] SIRQH_SLOT_SMI = 5'h03;
    localparam logic [4:0] SIRQH_SLOT_IOCHK = 5'h11;
    localparam logic [3:0] SIRQH_STOP_QUIET_CLK = 4'h2;
    localparam logic [3:0] SIRQH_STOP_CONT_CLK = 4'h3;

    // Idle clock unit scaling
    localparam int SIRQH_IDLE_UNIT_CLK = 4;

    typedef enum {
        SIRQH_ST_IDLE,
        SIRQH_ST_START,
        SIRQH_ST_START_REC,
        SIRQH_ST_START_TA,
        SIRQH_ST_SLOT,
        SIRQH_ST_STOP,
        SIRQH_ST_STOP_REC,
        SIRQH_ST_STOP_TA
    } sirqh_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } sirqh_cfg_req_t;

    typedef struct packed {
        logic en;
        logic cont;
        logic [1:0] pw;
    } sirqh_mode_t;

    typedef struct packed {
        logic iochk_lk;
        logic smi_lk;
        logic iochk_en;
        logic smi_en;
    } sirqh_exc_t;

endpackage

/* sirqh_properties.sv */
/* Concurrent checks on the sirqh_top ports.
   Assumes a bind from the bench and that every port is sampled on i_clk_sys. */
`timescale 1ns/1ps
module sirqh_properties
    import sirqh_pkg::*;
#(
    parameter int P_CLKSTOP_MIN_CLK = 4
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Configuration port
    input wire sirqh_cfg_req_t i_cfg,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic o_cfg_rvalid,
    // Clock stop and serial IRQ
    input wire logic i_clkrun_n,
    input wire logic i_clock_stop_protocol_enable,
    input wire logic o_lpc_clk_stop,
    input wire logic o_serirq,
    input wire logic o_serirq_oe,
    input wire logic o_smi_vw_n,
    input wire logic o_iochk_vw_n,
    input wire logic o_irq_clk_running
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Shortest idle wait in system clocks, with margin for the synchronisers
    localparam int MIN_SYS = P_CLKSTOP_MIN_CLK * 7;
    logic mapped;
    assign mapped = i_cfg.idx inside {SIRQH_IDX_IDLE_CNT, SIRQH_IDX_MODE, SIRQH_IDX_EXC, SIRQH_IDX_CLKG};
    sequence start_low_s;
        (o_serirq_oe && !o_serirq) [*8];
    endsequence
    sequence idle_long_s;
        i_clkrun_n && i_clock_stop_protocol_enable && $past(i_clkrun_n, MIN_SYS);
    endsequence
    fmt_const_a: assert property (i_cfg.rd && i_cfg.idx == SIRQH_IDX_MODE |=>
        o_cfg_rvalid && o_cfg_rdata[5:2] == SIRQH_FMT_21SLOT) else $error("format field wrong");
    idle_rsvd_a: assert property (i_cfg.rd && i_cfg.idx == SIRQH_IDX_IDLE_CNT |=>
        o_cfg_rvalid && o_cfg_rdata[1:0] == 2'h0) else $error("idle count reserved bits set");
    exc_rsvd_a: assert property (i_cfg.rd && i_cfg.idx == SIRQH_IDX_EXC |=>
        o_cfg_rdata[7:6] == 2'h0 && o_cfg_rdata[3:2] == 2'h0) else $error("exception reserved bits set");
    clkg_rsvd_a: assert property (i_cfg.rd && i_cfg.idx == SIRQH_IDX_CLKG |=>
        o_cfg_rdata[7:1] == 7'h00) else $error("clocking reserved bits set");
    unmapped_zero_a: assert property (i_cfg.rd && !mapped |=>
        o_cfg_rvalid && o_cfg_rdata == SIRQH_RD_UNMAPPED) else $error("unmapped read not zero");
    reset_outputs_a: assert property ($rose(i_nrst) |-> o_smi_vw_n && o_iochk_vw_n &&
        !o_serirq_oe && !o_lpc_clk_stop && o_irq_clk_running) else $error("outputs not at reset values");
    stop_gated_a: assert property (!i_clock_stop_protocol_enable |=> !o_lpc_clk_stop)
        else $error("clock stop while protocol off");
    stop_wait_a: assert property ($rose(o_lpc_clk_stop) |-> idle_long_s)
        else $error("clock stop too early");
    stop_drop_a: assert property ($fell(i_clkrun_n) |-> ##[1:5] !o_lpc_clk_stop)
        else $error("clock stop held while busy");
    start_width_a: assert property ($rose(o_serirq_oe) |-> start_low_s)
        else $error("start pulse too short");
endmodule

/* sirqh_sync.sv */
/*
 * Two-flop synchroniser bank with rising and falling edge pulses per bit.
 * Assumes inputs are asynchronous to i_clk_sys; edges are found on the second flop only.
 */
`timescale 1ns/1ps
module sirqh_sync
#(
    parameter int WIDTH = 3
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Asynchronous inputs
    input wire logic [WIDTH-1:0] i_async,
    // Synchronised level and edges
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge i_clk_sys)
            begin
                if (!i_nrst)
                begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                    prev_r[g] <= 1'b0;
                end
                else
                begin
                    meta_r[g] <= i_async[g];
                    sync_r[g] <= meta_r[g];
                    prev_r[g] <= sync_r[g];
                end
            end
            assign o_level[g] = sync_r[g];
            assign o_rise[g] = sync_r[g] & ~prev_r[g];
            assign o_fall[g] = ~sync_r[g] & prev_r[g];
        end
    endgenerate
endmodule

/* sirqh_top.sv */
/*
 * Serial IRQ host frame engine, its configuration registers and the clock-stop idle wait.
 * Assumes the LPC clock, clock-run line and serial IRQ line arrive asynchronously and
 * that configuration accesses come from logic on i_clk_sys.
 */
`timescale 1ns/1ps
module sirqh_top
    import sirqh_pkg::*;
#(
    parameter int P_CLKSTOP_MIN_CLK = 4
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Configuration port
    input wire sirqh_cfg_req_t i_cfg,
    output logic [7:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // LPC clock and clock-run handshake
    input wire logic i_lpc_clk,
    input wire logic i_clkrun_n,
    input wire logic i_clock_stop_protocol_enable,
    output logic o_lpc_clk_stop,
    // Serial IRQ pin
    input wire logic i_serirq,
    output logic o_serirq,
    output logic o_serirq_oe,
    // Forwarded virtual wires and status
    output logic o_smi_vw_n,
    output logic o_iochk_vw_n,
    output logic o_irq_clk_running
);
    logic [2:0] s_lvl;
    logic [2:0] s_rise;
    logic lpc_tick;
    logic clkrun_n_s;
    logic serirq_s;

    sirqh_sync #(.WIDTH(3)) u_sync
    (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_async({i_serirq, i_clkrun_n, i_lpc_clk}),
        .o_level(s_lvl),
        .o_rise(s_rise),
        .o_fall()
    );
    assign lpc_tick = s_rise[0];
    assign clkrun_n_s = s_lvl[1];
    assign serirq_s = s_lvl[2];

    // Configuration registers
    logic [5:0] idle_r, idle_nxt;
    sirqh_mode_t mode_r, mode_nxt;
    sirqh_exc_t exc_r, exc_nxt;
    logic clkg_r, clkg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb
    begin
        idle_nxt = idle_r;
        mode_nxt = mode_r;
        exc_nxt = exc_r;
        clkg_nxt = clkg_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = i_cfg.rd;
        if (i_cfg.wr)
        begin
            case (i_cfg.idx)
                SIRQH_IDX_IDLE_CNT:
                begin
                    idle_nxt = i_cfg.wdata[SIRQH_IDLE_MSB:SIRQH_IDLE_LSB];
                end
                SIRQH_IDX_MODE:
                begin
                    mode_nxt.en = i_cfg.wdata[SIRQH_MODE_EN_BIT];
                    mode_nxt.cont = i_cfg.wdata[SIRQH_MODE_MD_BIT];
                    mode_nxt.pw = i_cfg.wdata[SIRQH_MODE_PW_MSB:SIRQH_MODE_PW_LSB];
                end
                SIRQH_IDX_EXC:
                begin
                    if (!exc_r.iochk_lk)
                    begin
                        exc_nxt.iochk_en = i_cfg.wdata[SIRQH_EXC_IOCHK_EN_BIT];
                    end
                    if (!exc_r.smi_lk)
                    begin
                        exc_nxt.smi_en = i_cfg.wdata[SIRQH_EXC_SMI_EN_BIT];
                    end
                    exc_nxt.iochk_lk = exc_r.iochk_lk | i_cfg.wdata[SIRQH_EXC_IOCHK_LK_BIT];
                    exc_nxt.smi_lk = exc_r.smi_lk | i_cfg.wdata[SIRQH_EXC_SMI_LK_BIT];
                end
                SIRQH_IDX_CLKG:
                begin
                    clkg_nxt = i_cfg.wdata[SIRQH_CLKG_BIT];
                end
                default:
                begin
                    clkg_nxt = clkg_r;
                end
            endcase
        end
        if (i_cfg.rd)
        begin
            rdata_nxt = SIRQH_RD_UNMAPPED;
            case (i_cfg.idx)
                SIRQH_IDX_IDLE_CNT:
                begin
                    rdata_nxt[SIRQH_IDLE_MSB:SIRQH_IDLE_LSB] = idle_r;
                end
                SIRQH_IDX_MODE:
                begin
                    rdata_nxt[SIRQH_MODE_EN_BIT] = mode_r.en;
                    rdata_nxt[SIRQH_MODE_MD_BIT] = mode_r.cont;
                    rdata_nxt[SIRQH_MODE_FMT_MSB:SIRQH_MODE_FMT_LSB] = SIRQH_FMT_21SLOT;
                    rdata_nxt[SIRQH_MODE_PW_MSB:SIRQH_MODE_PW_LSB] = mode_r.pw;
                end
                SIRQH_IDX_EXC:
                begin
                    rdata_nxt[SIRQH_EXC_IOCHK_LK_BIT] = exc_r.iochk_lk;
                    rdata_nxt[SIRQH_EXC_SMI_LK_BIT] = exc_r.smi_lk;
                    rdata_nxt[SIRQH_EXC_IOCHK_EN_BIT] = exc_r.iochk_en;
                    rdata_nxt[SIRQH_EXC_SMI_EN_BIT] = exc_r.smi_en;
                end
                SIRQH_IDX_CLKG:
                begin
                    rdata_nxt[SIRQH_CLKG_BIT] = clkg_r;
                end
                default:
                begin
                    rdata_nxt = SIRQH_RD_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            idle_r <= SIRQH_IDLE_RST;
            mode_r <= '{en: 1'b0, cont: 1'b0, pw: SIRQH_PW_RST};
            exc_r <= '0;
            clkg_r <= SIRQH_CLKG_RST;
            rdata_r <= SIRQH_RD_UNMAPPED;
            rvalid_r <= 1'b0;
        end
        else
        begin
            idle_r <= idle_nxt;
            mode_r <= mode_nxt;
            exc_r <= exc_nxt;
            clkg_r <= clkg_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Clock-stop idle wait
    localparam int CSW = 10;
    localparam logic [CSW-1:0] CS_MIN = CSW'(P_CLKSTOP_MIN_CLK);
    logic [CSW-1:0] cs_cnt_r, cs_cnt_nxt;
    logic [CSW-1:0] cs_need;
    logic stop_r, stop_nxt;
    logic frame_busy;

    always_comb
    begin
        cs_need = CS_MIN + CSW'(idle_r) * CSW'(SIRQH_IDLE_UNIT_CLK);
        cs_cnt_nxt = cs_cnt_r;
        stop_nxt = stop_r;
        if (!i_clock_stop_protocol_enable || !clkrun_n_s)
        begin
            cs_cnt_nxt = '0;
            stop_nxt = 1'b0;
        end
        else if (lpc_tick && !stop_r)
        begin
            if (cs_cnt_r >= cs_need && !frame_busy)
            begin
                stop_nxt = 1'b1;
            end
            else if (cs_cnt_r < cs_need)
            begin
                cs_cnt_nxt = cs_cnt_r + CSW'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            cs_cnt_r <= '0;
            stop_r <= 1'b0;
        end
        else
        begin
            cs_cnt_r <= cs_cnt_nxt;
            stop_r <= stop_nxt;
        end
    end

    // Serial IRQ frame engine
    sirqh_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic drv_r, drv_nxt;
    logic oe_r, oe_nxt;
    logic smi_r, smi_nxt;
    logic iochk_r, iochk_nxt;
    logic [3:0] pw_clk;
    logic ftick;

    assign frame_busy = (st_r != SIRQH_ST_IDLE);

    always_comb
    begin
        case (mode_r.pw)
            SIRQH_PW_CODE_6: pw_clk = SIRQH_PW_CLK_6;
            SIRQH_PW_CODE_8: pw_clk = SIRQH_PW_CLK_8;
            default: pw_clk = SIRQH_PW_CLK_4;
        endcase
        // Frame clock stops only when gating allowed and nothing is pending
        ftick = lpc_tick & (clkg_r | frame_busy | mode_r.cont | ~serirq_s);
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        slot_nxt = slot_r;
        drv_nxt = drv_r;
        oe_nxt = oe_r;
        smi_nxt = exc_r.smi_en ? smi_r : 1'b1;
        iochk_nxt = exc_r.iochk_en ? iochk_r : 1'b1;
        if (ftick)
        begin
            case (st_r)
                SIRQH_ST_IDLE:
                begin
                    oe_nxt = 1'b0;
                    drv_nxt = 1'b1;
                    if (mode_r.en && (mode_r.cont || !serirq_s))
                    begin
                        st_nxt = SIRQH_ST_START;
                        cnt_nxt = pw_clk - 4'h1;
                        oe_nxt = 1'b1;
                        drv_nxt = 1'b0;
                    end
                end
                SIRQH_ST_START:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        st_nxt = SIRQH_ST_START_REC;
                        drv_nxt = 1'b1;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r - 4'h1;
                    end
                end
                SIRQH_ST_START_REC:
                begin
                    st_nxt = SIRQH_ST_START_TA;
                    oe_nxt = 1'b0;
                end
                SIRQH_ST_START_TA:
                begin
                    st_nxt = SIRQH_ST_SLOT;
                    slot_nxt = 5'h00;
                    cnt_nxt = 4'h0;
                end
                SIRQH_ST_SLOT:
                begin
                    if (cnt_r == 4'h0 && slot_r == SIRQH_SLOT_SMI && exc_r.smi_en)
                    begin
                        smi_nxt = serirq_s;
                    end
                    if (cnt_r == 4'h0 && slot_r == SIRQH_SLOT_IOCHK && exc_r.iochk_en)
                    begin
                        iochk_nxt = serirq_s;
                    end
                    if (cnt_r == 4'(SIRQH_SLOT_PHASES - 2'h1))
                    begin
                        cnt_nxt = 4'h0;
                        slot_nxt = slot_r + 5'h01;
                        if (slot_r == SIRQH_NUM_SLOTS - 5'h01)
                        begin
                            st_nxt = SIRQH_ST_STOP;
                            cnt_nxt = (mode_r.cont ? SIRQH_STOP_CONT_CLK : SIRQH_STOP_QUIET_CLK) - 4'h1;
                            oe_nxt = 1'b1;
                            drv_nxt = 1'b0;
                        end
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                SIRQH_ST_STOP:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        st_nxt = SIRQH_ST_STOP_REC;
                        drv_nxt = 1'b1;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r - 4'h1;
                    end
                end
                SIRQH_ST_STOP_REC:
                begin
                    st_nxt = SIRQH_ST_STOP_TA;
                    oe_nxt = 1'b0;
                end
                SIRQH_ST_STOP_TA:
                begin
                    st_nxt = SIRQH_ST_IDLE;
                end
                default:
                begin
                    st_nxt = SIRQH_ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            st_r <= SIRQH_ST_IDLE;
            cnt_r <= 4'h0;
            slot_r <= 5'h00;
            drv_r <= 1'b1;
            oe_r <= 1'b0;
            smi_r <= 1'b1;
            iochk_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            slot_r <= slot_nxt;
            drv_r <= drv_nxt;
            oe_r <= oe_nxt;
            smi_r <= smi_nxt;
            iochk_r <= iochk_nxt;
        end
    end

    // Frame clock activity flag
    logic run_r, run_nxt;
    always_comb
    begin
        run_nxt = clkg_r | frame_busy | mode_r.cont | ~serirq_s;
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            run_r <= 1'b1;
        end
        else
        begin
            run_r <= run_nxt;
        end
    end

    assign o_cfg_rdata = rdata_r;
    assign o_cfg_rvalid = rvalid_r;
    assign o_lpc_clk_stop = stop_r;
    assign o_serirq = drv_r;
    assign o_serirq_oe = oe_r;
    assign o_smi_vw_n = smi_r;
    assign o_iochk_vw_n = iochk_r;
    assign o_irq_clk_running = run_r;
endmodule

/* tb_top.sv */
/* Self-checking bench for sirqh_top with the peripheral model.
   Assumes the package, the design, the model and the checker are compiled first. */
`timescale 1ns/1ps
module tb_top
    import sirqh_pkg::*;
;
    logic clk = 1'b0;
    logic lpc_clk = 1'b0;
    logic nrst = 1'b0;
    sirqh_cfg_req_t cfg = '0;
    logic idle_req_n = 1'b0;
    logic stop_en = 1'b0;
    logic s3_low = 1'b1;
    logic s17_low = 1'b1;
    logic wake_n = 1'b1;
    logic [7:0] rdata;
    logic rvalid, stop, out, oe, smi_n, iochk_n, running, drv_low, line;
    int miscompares = 0;
    int n_compared = 0;
    assign line = (oe ? out : 1'b1) & ~drv_low & wake_n;
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #3;
        forever #40 lpc_clk = ~lpc_clk;
    end
    sirqh_top #(.P_CLKSTOP_MIN_CLK(4)) i_sirqh_top (.i_clk_sys(clk), .i_nrst(nrst), .i_cfg(cfg),
        .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_lpc_clk(lpc_clk), .i_clkrun_n(idle_req_n),
        .i_clock_stop_protocol_enable(stop_en), .o_lpc_clk_stop(stop), .i_serirq(line), .o_serirq(out),
        .o_serirq_oe(oe), .o_smi_vw_n(smi_n), .o_iochk_vw_n(iochk_n), .o_irq_clk_running(running));
    sirqh_periph i_sirqh_periph (.i_lpc_clk(lpc_clk), .i_host_oe(oe), .i_slot3_low(s3_low),
        .i_slot17_low(s17_low), .o_drive_low(drv_low));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
    endtask
    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        #1 cfg = '{1'b1, 1'b0, idx, d};
        @(posedge clk);
        #1 cfg.wr = 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge clk);
        #1 cfg = '{1'b0, 1'b1, idx, 8'h00};
        @(posedge clk);
        #1 cfg.rd = 1'b0;
        check("rvalid", 8'h01, {7'h00, rvalid});
        check("rdata", exp, rdata);
    endtask
    task automatic frames(input int n);
        int t;
        repeat (n)
        begin
            for (t = 0; t < 3000 && oe !== 1'b0; t++) @(posedge clk);
            for (t = 0; t < 3000 && oe !== 1'b1; t++) @(posedge clk);
            check("frame_drive", 8'h01, {7'h00, oe});
        end
    endtask
    task automatic pulse(input logic [1:0] code, input logic [7:0] exp);
        logic [7:0] n;
        cfg_wr(SIRQH_IDX_MODE, {6'h30, code});
        n = 8'h00;
        // Stop pulses are at most three clocks, so a shorter one is skipped
        repeat (3)
        begin
            if (n < 8'h04)
            begin
                n = 8'h00;
                frames(1);
                @(posedge lpc_clk);
                while (oe === 1'b1 && out === 1'b0)
                begin
                    n++;
                    @(posedge lpc_clk);
                end
            end
        end
        check("start_width", exp, n);
        cfg_rd(SIRQH_IDX_MODE, {6'h34, code});
    endtask
    task automatic stop_wait(input logic [5:0] idle);
        int n;
        cfg_wr(SIRQH_IDX_IDLE_CNT, {idle, 2'b00});
        @(posedge clk);
        #1 idle_req_n = 1'b0;
        stop_en = 1'b1;
        repeat (3) @(posedge lpc_clk);
        check("clk_stop_busy", 8'h00, {7'h00, stop});
        @(posedge clk);
        #1 idle_req_n = 1'b1;
        for (n = 0; n < 100 && stop !== 1'b1; n++) @(posedge lpc_clk);
        check("clk_stop_wait", 8'h01, {7'h00, n >= 5 + 4 * idle && n <= 8 + 4 * idle});
    endtask
    task automatic quiet_mode;
        int t;
        cfg_wr(SIRQH_IDX_MODE, 8'h80);
        repeat (800) @(posedge clk);
        for (t = 0; t < 1000 && oe !== 1'b1; t++) @(posedge clk);
        check("quiet_idle", 8'h00, {7'h00, oe});
        #1 wake_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 wake_n = 1'b1;
        frames(1);
    endtask
    task automatic read_defaults;
        cfg_rd(SIRQH_IDX_IDLE_CNT, 8'h00);
        cfg_rd(SIRQH_IDX_MODE, 8'h10);
        cfg_rd(SIRQH_IDX_EXC, 8'h00);
        cfg_rd(SIRQH_IDX_CLKG, 8'h01);
        cfg_rd(8'h41, SIRQH_RD_UNMAPPED);
    endtask
    initial
    begin
        #500000;
        miscompares++;
        give_verdict;
    end
    initial
    begin
        do_reset;
        read_defaults;
        cfg_wr(SIRQH_IDX_IDLE_CNT, 8'hFF);
        cfg_rd(SIRQH_IDX_IDLE_CNT, 8'hFC);
        cfg_wr(8'h41, 8'hFF);
        cfg_rd(8'h41, 8'h00);
        @(posedge clk);
        #1 idle_req_n = 1'b1;
        repeat (40) @(posedge lpc_clk);
        check("clk_stop_off", 8'h00, {7'h00, stop});
        check("no_frame", 8'h00, {7'h00, oe});
        check("irq_clk_on", 8'h01, {7'h00, running});
        stop_wait(6'd0);
        stop_wait(6'd3);
        cfg_wr(SIRQH_IDX_CLKG, 8'hFE);
        cfg_rd(SIRQH_IDX_CLKG, 8'h00);
        repeat (10) @(posedge lpc_clk);
        check("irq_clk_gated", 8'h00, {7'h00, running});
        cfg_wr(SIRQH_IDX_CLKG, 8'h01);
        pulse(2'h0, 8'h04);
        pulse(2'h1, 8'h06);
        pulse(2'h2, 8'h08);
        pulse(2'h3, 8'h04);
        frames(3);
        check("smi_off", 8'h01, {7'h00, smi_n});
        check("iochk_off", 8'h01, {7'h00, iochk_n});
        cfg_wr(SIRQH_IDX_EXC, 8'h03);
        frames(3);
        check("smi_on", 8'h00, {7'h00, smi_n});
        check("iochk_on", 8'h00, {7'h00, iochk_n});
        @(posedge clk);
        #1 s3_low = 1'b0;
        frames(3);
        check("smi_idle", 8'h01, {7'h00, smi_n});
        cfg_wr(SIRQH_IDX_EXC, 8'h33);
        cfg_wr(SIRQH_IDX_EXC, 8'h00);
        cfg_rd(SIRQH_IDX_EXC, 8'h33);
        frames(3);
        check("iochk_locked", 8'h00, {7'h00, iochk_n});
        quiet_mode;
        do_reset;
        read_defaults;
        give_verdict;
    end
endmodule
bind sirqh_top sirqh_properties #(.P_CLKSTOP_MIN_CLK(P_CLKSTOP_MIN_CLK)) i_sirqh_properties (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rvalid(o_cfg_rvalid), .i_clkrun_n(i_clkrun_n),
    .i_clock_stop_protocol_enable(i_clock_stop_protocol_enable), .o_lpc_clk_stop(o_lpc_clk_stop),
    .o_serirq(o_serirq), .o_serirq_oe(o_serirq_oe), .o_smi_vw_n(o_smi_vw_n),
    .o_iochk_vw_n(o_iochk_vw_n), .o_irq_clk_running(o_irq_clk_running));
